// >>> state_capture_trigger.v
// State-mode capture and trigger block with APB register access.
// Assumes probe pins and the state clock are asynchronous, slow relative to ref_clk_i.
// Contract
// - Sample channels only on edges of the external state clock.
// - State clock selectable off, rising or falling; default falling.
// - Data label is pod 1; address is pod 2 plus pod 3 low eight bits.
// - Compare sampled address with programmed pattern; all zeros matches by default.
// - Eight qualifiers a to h, each with per-label pattern, one selectable.
// - Trigger on first qualifier match, then post-trigger storage.
// - Before trigger store every sampled state continuously.
// - After trigger store every state, stop after half the memory depth.
// - Trigger sample sits at centre of the stored record.
// - Nothing stored or triggered until a run command arms capture.
`include "state_capture_defs.vh"
`default_nettype none
module state_capture_trigger #(
    parameter AW_BITS = 10
)
(
    input wire ref_clk_i,
    input wire rst_i,
    input wire [15:0] pod1_i,
    input wire [15:0] pod2_i,
    input wire [15:0] pod3_i,
    input wire state_clk_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq_o
);
    localparam DEPTH = 1 << AW_BITS;
    localparam ST_IDLE = 2'd0;
    localparam ST_PRE = 2'd1;
    localparam ST_POST = 2'd2;
    localparam ST_DONE = 2'd3;
    reg [39:0] mem [0:DEPTH-1];
    reg [1:0] state;
    reg [31:0] ctrl;
    reg [2:0] trig_sel;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [AW_BITS-1:0] rd_index;
    reg [AW_BITS-1:0] wr_ptr;
    reg [AW_BITS-1:0] trig_ptr;
    reg [AW_BITS-1:0] post_cnt;
    reg wrapped;
    reg [39:0] rd_word;
    reg [191:0] qaddr;
    reg [191:0] qamask;
    reg [127:0] qdata;
    reg [127:0] qdmask;
    reg [47:0] p1;
    reg [47:0] p2;
    reg [47:0] p3;
    reg [23:0] smp_addr;
    reg [15:0] smp_data;
    reg smp_valid;
    reg run_prev;
    wire strobe;
    wire [7:0] match;
    wire acc;
    wire wr_acc;
    wire rd_acc;
    wire trig_hit;
    wire [2:0] qidx;
    wire [1:0] qsel;
    wire [1:0] irq_set;
    wire run_rise;
    wire addr_ok;
    wire [AW_BITS-1:0] rd_slot;
    reg [31:0] next_rdata;
    integer i;

    edge_sampler u_edge (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_pin_i(state_clk_i),
        .enable_i(ctrl[`CTRL_CLK_EN_BIT]),
        .rising_i(ctrl[`CTRL_CLK_RISE_BIT]),
        .strobe_o(strobe)
    );

    qualifier_bank #(
        .NQ(8),
        .AW(24),
        .DW(16)
    ) u_qual (
        .qaddr_i(qaddr),
        .qamask_i(qamask),
        .qdata_i(qdata),
        .qdmask_i(qdmask),
        .addr_i(smp_addr),
        .data_i(smp_data),
        .match_o(match)
    );

    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign qidx = paddr[4:2];
    assign qsel = paddr[6:5];
    assign run_rise = ctrl[`CTRL_RUN_BIT] & ~run_prev;
    assign trig_hit = (state == ST_PRE) && smp_valid && match[trig_sel];
    assign irq_set = {(state == ST_POST) && smp_valid && (post_cnt == DEPTH/2 - 1), trig_hit};
    // Control block at 0x00-0x1C, qualifier banks at 0x40-0xBC; the rest is refused
    assign addr_ok = (paddr[11:8] == 4'h0) && ((paddr[7:5] == 3'h0) || (paddr[7:5] >= 3'h2 && paddr[7:5] <= 3'h5));
    // Same width as the pointers, so the sum wraps around the circular record
    assign rd_slot = rd_index + trig_ptr;

    // Pins go through three flops; data is caught on the cycle the clock edge is confirmed
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            p1 <= 48'h0;
            p2 <= 48'h0;
            p3 <= 48'h0;
            smp_addr <= 24'h0;
            smp_data <= 16'h0;
            smp_valid <= 1'b0;
        end
        else
        begin
            p1 <= {pod3_i, pod2_i, pod1_i};
            p2 <= p1;
            p3 <= p2;
            smp_valid <= strobe;
            if (strobe)
            begin
                // Probes are assumed stable around the edge, so the lagging copy is a clean state
                smp_data <= p3[15:0];
                smp_addr <= {p3[39:32], p3[31:16]};
            end
        end
    end

    // Acquisition sequencer
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            wr_ptr <= {AW_BITS{1'b0}};
            trig_ptr <= {AW_BITS{1'b0}};
            post_cnt <= {AW_BITS{1'b0}};
            wrapped <= 1'b0;
            run_prev <= 1'b0;
        end
        else
        begin
            run_prev <= ctrl[`CTRL_RUN_BIT];
            case (state)
                ST_IDLE:
                begin
                    if (run_rise)
                    begin
                        state <= ST_PRE;
                        wr_ptr <= {AW_BITS{1'b0}};
                        post_cnt <= {AW_BITS{1'b0}};
                        wrapped <= 1'b0;
                    end
                end
                ST_PRE:
                begin
                    if (!ctrl[`CTRL_RUN_BIT])
                        state <= ST_IDLE;
                    else if (smp_valid)
                    begin
                        wr_ptr <= wr_ptr + 1'b1;
                        if (&wr_ptr)
                            wrapped <= 1'b1;
                        if (trig_hit)
                        begin
                            trig_ptr <= wr_ptr;
                            state <= ST_POST;
                        end
                    end
                end
                ST_POST:
                begin
                    if (!ctrl[`CTRL_RUN_BIT])
                        state <= ST_IDLE;
                    else if (smp_valid)
                    begin
                        wr_ptr <= wr_ptr + 1'b1;
                        post_cnt <= post_cnt + 1'b1;
                        // Half depth after trigger centres it; fewer pre-trigger states if it came early
                        if (post_cnt == DEPTH/2 - 1)
                            state <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    if (!ctrl[`CTRL_RUN_BIT])
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Capture memory, written only while acquiring
    always @(posedge ref_clk_i)
    begin
        if (smp_valid && (state == ST_PRE || state == ST_POST))
            mem[wr_ptr] <= {smp_addr, smp_data};
        rd_word <= mem[rd_slot];
    end

    always @*
    begin
        next_rdata = 32'h0;
        case (paddr[7:2])
            6'h00: next_rdata = ctrl;
            6'h01: next_rdata = {27'h0, wrapped, 2'h0, state};
            6'h02: next_rdata = {30'h0, irq_status};
            6'h03: next_rdata = {30'h0, irq_mask};
            6'h04: next_rdata = {29'h0, trig_sel};
            6'h05: next_rdata = {{(32-AW_BITS){1'b0}}, rd_index};
            6'h06: next_rdata = {8'h0, rd_word[39:16]};
            6'h07: next_rdata = {16'h0, rd_word[15:0]};
            default:
            begin
                case (qsel)
                    2'h2: next_rdata = {8'h0, qaddr[qidx*24 +: 24]};
                    2'h3: next_rdata = {16'h0, qdata[qidx*16 +: 16]};
                    default: next_rdata = 32'h0;
                endcase
                if (paddr[7:5] == 3'h4)
                    next_rdata = {8'h0, qamask[qidx*24 +: 24]};
                else if (paddr[7:5] == 3'h5)
                    next_rdata = {16'h0, qdmask[qidx*16 +: 16]};
            end
        endcase
    end

    // APB slave: one wait state, so read data from memory settles first
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            ctrl <= `CTRL_RESET;
            trig_sel <= `TRIG_SEL_RESET;
            irq_mask <= 2'h0;
            irq_status <= 2'h0;
            irq_o <= 1'b0;
            rd_index <= {AW_BITS{1'b0}};
            qaddr <= 192'h0;
            qamask <= {192{1'b1}};
            qdata <= 128'h0;
            qdmask <= 128'h0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            irq_o <= |(irq_status & irq_mask);
            // Set wins over the read clear
            // Only bits already reported are cleared, so an event during the read survives
            if (rd_acc && pready && paddr == `REG_IRQ_STATUS)
                irq_status <= (irq_status & ~prdata[1:0]) | irq_set;
            else
                irq_status <= irq_status | irq_set;
            if (acc && !pready)
                prdata <= (pwrite || !addr_ok) ? 32'h0 : next_rdata;
            if (wr_acc && pready && addr_ok)
            begin
                case (paddr[7:2])
                    6'h00: ctrl <= {29'h0, pwdata[2:0]};
                    6'h03: irq_mask <= pwdata[1:0];
                    6'h04: trig_sel <= pwdata[2:0];
                    6'h05: rd_index <= pwdata[AW_BITS-1:0];
                    default:
                    begin
                        for (i = 0; i < 8; i = i + 1)
                        begin
                            if (qidx == i[2:0] && paddr[7:5] == 3'h2)
                                qaddr[i*24 +: 24] <= pwdata[23:0];
                            if (qidx == i[2:0] && paddr[7:5] == 3'h3)
                                qdata[i*16 +: 16] <= pwdata[15:0];
                            if (qidx == i[2:0] && paddr[7:5] == 3'h4)
                                qamask[i*24 +: 24] <= pwdata[23:0];
                            if (qidx == i[2:0] && paddr[7:5] == 3'h5)
                                qdmask[i*16 +: 16] <= pwdata[15:0];
                        end
                    end
                endcase
            end
        end
    end
endmodule // state_capture_trigger
`default_nettype wire

// >>> state_capture_defs.vh
// Constants of the state capture and trigger block: register map, fields, resets.
// Assumes a 32-bit APB with word-aligned registers.
`ifndef STATE_CAPTURE_DEFS_VH
`define STATE_CAPTURE_DEFS_VH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_TRIG_SEL 12'h010
`define REG_RD_INDEX 12'h014
`define REG_RD_ADDR 12'h018
`define REG_RD_DATA 12'h01C
`define REG_QUAL_ADDR_BASE 12'h040
`define REG_QUAL_DATA_BASE 12'h060
`define REG_QUAL_AMASK_BASE 12'h080
`define REG_QUAL_DMASK_BASE 12'h0A0
`define CTRL_RUN_BIT 0
`define CTRL_CLK_EN_BIT 1
`define CTRL_CLK_RISE_BIT 2
`define CTRL_RESET 32'h0000_0002
`define TRIG_SEL_RESET 3'h0
`define IRQ_TRIG_BIT 0
`define IRQ_DONE_BIT 1
`define EDGE_SYNC_STAGES 3
`endif

// >>> edge_sampler.v
// State clock edge detector: three-flop synchroniser on the probe clock pin.
// Assumes the probe clock is far slower than the reference clock.
`default_nettype none
module edge_sampler
(
    input wire ref_clk_i,
    input wire rst_i,
    input wire clk_pin_i,
    input wire enable_i,
    input wire rising_i,
    output reg strobe_o
);
    reg s1;
    reg s2;
    reg s3;
    wire edge_rise;
    wire edge_fall;
    assign edge_rise = s2 & ~s3;
    assign edge_fall = ~s2 & s3;
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            strobe_o <= 1'b0;
        end
        else
        begin
            s1 <= clk_pin_i;
            s2 <= s1;
            s3 <= s2;
            // Off disables sampling entirely
            strobe_o <= enable_i & (rising_i ? edge_rise : edge_fall);
        end
    end
endmodule // edge_sampler
`default_nettype wire

// >>> qualifier_bank.v
// Eight pattern qualifiers, each an address and data pattern with don't-care masks.
// Patterns are written by the register block; matching is combinational.
`default_nettype none
module qualifier_bank #(
    parameter NQ = 8,
    parameter AW = 24,
    parameter DW = 16
)
(
    input wire [NQ*AW-1:0] qaddr_i,
    input wire [NQ*AW-1:0] qamask_i,
    input wire [NQ*DW-1:0] qdata_i,
    input wire [NQ*DW-1:0] qdmask_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] data_i,
    output wire [NQ-1:0] match_o
);
    genvar g;
    generate
        for (g = 0; g < NQ; g = g + 1)
        begin : q
            // Mask bit set means the bit must equal the pattern
            assign match_o[g] = (((addr_i ^ qaddr_i[g*AW +: AW]) & qamask_i[g*AW +: AW]) == {AW{1'b0}}) &&
                (((data_i ^ qdata_i[g*DW +: DW]) & qdmask_i[g*DW +: DW]) == {DW{1'b0}});
        end
    endgenerate
endmodule // qualifier_bank
`default_nettype wire

// >>> state_capture_trigger_sva.sv
// Checker for the bus and interrupt ports of the capture block.
// Assumes one clock domain; bound to every instance of the top module.
`include "state_capture_defs.vh"
`default_nettype none
module state_capture_trigger_sva #(
    parameter AW_BITS = 10
)
(
    input wire ref_clk_i,
    input wire rst_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_setup_access;
        (psel && !penable) ##1 (psel && penable);
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    chk_one_wait: assert property (s_setup_access |-> !pready ##1 pready) else $error("ready not after one wait");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("ready without access");
    chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_unmapped_err: assert property (s_done and (paddr >= 12'h0C0) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (pready && paddr < 12'h020 |-> !pslverr) else $error("mapped access refused");
    chk_irq_rdclr: assert property (s_done and (!pwrite && paddr == `REG_IRQ_STATUS) |-> ##2 !irq_o)
        else $error("irq not cleared by read");
    chk_irq_masked: assert property (s_done and (pwrite && paddr == `REG_IRQ_MASK && pwdata == 32'h0) |-> ##2 !irq_o)
        else $error("irq high with mask clear");
endmodule // state_capture_trigger_sva
bind state_capture_trigger state_capture_trigger_sva #(.AW_BITS(AW_BITS)) u_sva (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
`default_nettype wire

// >>> target_bus_model.sv
// Target bus model: drives the probe pods and the state clock in bursts.
// Assumes the bench starts one burst at a time and waits for busy to fall.
`default_nettype none
module target_bus_model
(
    input wire logic ref_clk_i,
    input wire logic start_i,
    input wire logic [7:0] count_i,
    input wire logic [7:0] trig_at_i,
    input wire logic [23:0] trig_addr_i,
    output logic busy_o,
    output logic state_clk_o,
    output logic [15:0] pod1_o,
    output logic [15:0] pod2_o,
    output logic [15:0] pod3_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] addr;
    initial
    begin
        busy_o = 1'b0;
        state_clk_o = 1'b0;
        pod1_o = 16'h5A5A;
        pod2_o = 16'hA5A5;
        pod3_o = 16'h5A5A;
        forever
        begin
            @(posedge ref_clk_i);
            if (start_i === 1'b1)
            begin
                busy_o <= 1'b1;
                for (int n = 0; n < count_i; n++)
                begin
                    addr = (n == trig_at_i) ? trig_addr_i : 24'h010000 + 24'(n);
                    pod1_o <= 16'hD000 + 16'(n);
                    pod2_o <= addr[15:0];
                    pod3_o <= {8'hFF, addr[23:16]};
                    // Six cycles of hold around either edge, so both edge settings see one state
                    repeat (6) @(posedge ref_clk_i);
                    state_clk_o <= 1'b1;
                    repeat (6) @(posedge ref_clk_i);
                    state_clk_o <= 1'b0;
                    repeat (6) @(posedge ref_clk_i);
                end
                // Pod 1 and pod 2 lines let go between bursts; show the inverse, not a held state
                pod1_o <= ~pod1_o;
                pod2_o <= ~pod2_o;
                busy_o <= 1'b0;
            end
        end
    end
endmodule // target_bus_model
`default_nettype wire

// >>> state_capture_trigger_tb.sv
// Bench for the capture block: APB register tests and capture runs.
// Assumes a 16-deep memory (AW_BITS 4) and the target bus model.
`include "state_capture_defs.vh"
`default_nettype none
module state_capture_trigger_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_o, state_clk, busy, err;
    logic start = 1'b0;
    logic [15:0] pod1, pod2, pod3;
    logic [7:0] trig_at = 8'h00;
    logic [7:0] count = 8'h00;
    logic [23:0] trig_addr = 24'h0;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    state_capture_trigger #(.AW_BITS(4)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pod1_i(pod1),
        .pod2_i(pod2), .pod3_i(pod3), .state_clk_i(state_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
    target_bus_model u_target (.ref_clk_i(ref_clk_i), .start_i(start), .count_i(count), .trig_at_i(trig_at),
        .trig_addr_i(trig_addr), .busy_o(busy), .state_clk_o(state_clk), .pod1_o(pod1), .pod2_o(pod2),
        .pod3_o(pod3));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // Ready, read data and error are all taken at the rising edge that completes the access
        do
        begin
            @(posedge ref_clk_i);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t >= 50)
            check("apb ready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask
    task automatic burst(input logic [7:0] n, input logic [7:0] tr, input logic [23:0] ta);
        int t;
        t = 0;
        @(posedge ref_clk_i);
        count <= n;
        trig_at <= tr;
        trig_addr <= ta;
        start <= 1'b1;
        do
        begin
            @(negedge ref_clk_i);
            t++;
        end
        while (busy !== 1'b1 && t < 20);
        if (t >= 20)
            check("burst start", 32'h1, 32'h0);
        @(posedge ref_clk_i);
        start <= 1'b0;
        do
        begin
            @(negedge ref_clk_i);
            t++;
        end
        while (busy !== 1'b0 && t < 3000);
        if (t >= 3000)
            check("burst end", 32'h1, 32'h0);
    endtask
    task automatic readback(input int tr, input logic [23:0] ta);
        int s;
        // Slot DEPTH/2 holds the last post sample, written over the oldest pre one
        for (int i = 0; i < DEPTH; i++)
        begin
            s = tr + (i <= DEPTH / 2 ? i : i - DEPTH);
            apb(1'b1, `REG_RD_INDEX, 32'(i));
            rdchk("address", `REG_RD_ADDR, {8'h00, (s == tr) ? ta : 24'h010000 + 24'(s)});
            rdchk("data", `REG_RD_DATA, {16'h0000, 16'hD000 + 16'(s)});
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl", `REG_CTRL, `CTRL_RESET);
        rdchk("qual a mask", `REG_QUAL_AMASK_BASE, 32'h00FF_FFFF);
        apb(1'b1, 12'h0C0, 32'hFFFF_FFFF);
        check("unmapped write", 32'h1, {31'h0, err});
        rdchk("unmapped read", 12'h0C0, 32'h0);
        burst(8'd5, 8'd2, 24'h0);
        rdchk("unarmed status", `REG_STATUS, 32'h0);
        rdchk("unarmed irq", `REG_IRQ_STATUS, 32'h0);
        apb(1'b1, `REG_IRQ_MASK, 32'h3);
        apb(1'b1, `REG_CTRL, 32'h3);
        rdchk("armed status", `REG_STATUS, 32'h1);
        burst(8'd30, 8'd10, 24'h0);
        rdchk("done status", `REG_STATUS, 32'h3);
        check("irq raised", 32'h1, {31'h0, irq_o});
        rdchk("irq status", `REG_IRQ_STATUS, 32'h3);
        repeat (2) @(negedge ref_clk_i);
        check("irq cleared", 32'h0, {31'h0, irq_o});
        readback(10, 24'h0);
        apb(1'b1, `REG_CTRL, 32'h2);
        apb(1'b1, `REG_IRQ_MASK, 32'h0);
        apb(1'b1, `REG_QUAL_ADDR_BASE + 12'h01C, 32'h0012_3456);
        apb(1'b1, `REG_TRIG_SEL, 32'h7);
        apb(1'b1, `REG_CTRL, 32'h7);
        burst(8'd20, 8'd9, 24'h123456);
        check("irq masked", 32'h0, {31'h0, irq_o});
        rdchk("masked irq status", `REG_IRQ_STATUS, 32'h3);
        readback(9, 24'h123456);
        apb(1'b1, `REG_CTRL, 32'h2);
        apb(1'b1, `REG_CTRL, 32'h1);
        burst(8'd20, 8'd3, 24'h0);
        rdchk("clock off status", `REG_STATUS, 32'h1);
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        final_report();
    end
endmodule // state_capture_trigger_tb
`default_nettype wire
